//--- verilog/mex_exec.sv
`timescale 1ns/100ps
module mex_exec
    import mex_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PROG_W = 13
) (
    // Clock, reset, enable
    input  wire logic                clk_sys_i,
    input  wire logic                rstn_i,
    input  wire logic                ce_i,
    // Instruction request from sequencer
    input  wire logic                start_i,
    input  wire mex_op_t             op_i,
    input  wire logic [ADDR_W-1:0]   mem_addr_i,
    input  wire logic [2:0]          bit_sel_i,
    input  wire logic [MEX_DW-1:0]   imm_i,
    input  wire logic                to_mem_i,
    output logic                     busy_o,
    output logic                     done_o,
    output logic                     skip_o,
    // Data memory port
    output logic                     dmem_rd_o,
    output logic                     dmem_wr_o,
    output logic [ADDR_W-1:0]        dmem_addr_o,
    output logic [MEX_DW-1:0]        dmem_wdata_o,
    input  wire logic [MEX_DW-1:0]   dmem_rdata_i,
    // Program memory port
    output logic                     pmem_rd_o,
    output logic [PROG_W-1:0]        pmem_addr_o,
    input  wire logic [MEX_PW-1:0]   pmem_rdata_i,
    // Table pointer load
    input  wire logic                tbl_low_wr_i,
    input  wire logic                tbl_high_wr_i,
    input  wire logic [MEX_DW-1:0]   tbl_wdata_i,
    // Architectural state
    output logic [MEX_DW-1:0]        working_register_o,
    output logic [MEX_DW-1:0]        table_pointer_low_o,
    output logic [MEX_DW-1:0]        table_pointer_high_o,
    output logic [MEX_DW-1:0]        table_high_latch_o,
    output logic                     carry_o,
    output logic                     nibble_half_flag_o,
    output logic                     zero_o,
    output logic                     signed_range_flag_o,
    output logic                     aux_signed_flag_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                rst_q1;
        logic                rst_q2;
        mex_state_t          st;
        mex_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [2:0]          bsel;
        logic [MEX_DW-1:0]   imm;
        logic                to_mem;
        logic                skip_pend;
        logic [MEX_DW-1:0]   acc;
        logic [MEX_DW-1:0]   tlo;
        logic [MEX_DW-1:0]   thi;
        logic [MEX_DW-1:0]   tlatch;
        logic [MEX_FLAG_W-1:0] flags;
        logic                dmem_rd;
        logic                dmem_wr;
        logic [MEX_DW-1:0]   wdata;
        logic                pmem_rd;
        logic [PROG_W-1:0]   paddr;
        logic                done;
        logic                skip;
    } mex_state_reg_t;

    mex_state_reg_t s_reg;
    mex_state_reg_t s_next;
    logic           rstn_sync;

    assign rstn_sync = s_reg.rst_q2;

    // Zero test helper
    function automatic logic is_zero(input logic [MEX_DW-1:0] v);
        return v == MEX_ZERO;
    endfunction
    // Table fetch opcodes, used by the sequencer and the checks
    function automatic logic is_table(input mex_op_t o);
        return o inside {MEX_OP_TBL_PAGED, MEX_OP_TBL_FINAL, MEX_OP_TBL_PAGED_PI, MEX_OP_TBL_FINAL_PI};
    endfunction

    // Program address; final page means all upper bits set
    function automatic logic [PROG_W-1:0] tbl_addr(input logic final_pg,
                                                   input logic [MEX_DW-1:0] hi,
                                                   input logic [MEX_DW-1:0] lo);
        logic [PROG_W-1:0] a;
        a = {{(PROG_W-MEX_DW){1'b1}}, lo};
        if (!final_pg) begin
            a[PROG_W-1:MEX_DW] = hi[PROG_W-MEX_DW-1:0];
        end
        return a;
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [MEX_DW:0]   sum;
        logic [MEX_NIB:0]  lsum;
        logic              cin;
        logic [MEX_DW-1:0] m;
        logic [MEX_DW-1:0] res;
        logic [MEX_DW:0]   bcd;
        logic              lo_fix;
        logic              hi_fix;
        sum    = '0;
        lsum   = '0;
        cin    = 1'b0;
        m      = dmem_rdata_i;
        res    = '0;
        bcd    = '0;
        lo_fix = 1'b0;
        hi_fix = 1'b0;
        s_next = s_reg;
        s_next.rst_q1  = 1'b1;
        s_next.rst_q2  = s_reg.rst_q1;
        s_next.dmem_rd = 1'b0;
        s_next.dmem_wr = 1'b0;
        s_next.pmem_rd = 1'b0;
        s_next.done    = 1'b0;
        s_next.skip    = 1'b0;
        if (tbl_low_wr_i) begin
            s_next.tlo = tbl_wdata_i;
        end
        if (tbl_high_wr_i) begin
            s_next.thi = tbl_wdata_i;
        end
        case (s_reg.st)
            MEX_ST_IDLE: begin
                if (start_i && s_reg.skip_pend) begin
                    // Suppressed instruction: nothing latched or written
                    s_next.skip_pend = 1'b0;
                    s_next.done      = 1'b1;
                end else if (start_i && op_i != MEX_OP_NOP) begin
                    s_next.op     = op_i;
                    s_next.addr   = mem_addr_i;
                    s_next.bsel   = bit_sel_i;
                    s_next.imm    = imm_i;
                    s_next.to_mem = to_mem_i;
                    s_next.st     = MEX_ST_READ;
                    s_next.dmem_rd = 1'b1;
                    if (op_i == MEX_OP_TBL_PAGED_PI || op_i == MEX_OP_TBL_FINAL_PI) begin
                        s_next.tlo = s_reg.tlo + MEX_ONE;
                    end
                end else if (start_i) begin
                    s_next.done = 1'b1;
                end
            end
            MEX_ST_READ: begin
                // Data byte valid next cycle; table ops also need the program word
                s_next.st = MEX_ST_EXEC;
                if (is_table(s_reg.op)) begin
                    s_next.pmem_rd = 1'b1;
                    s_next.paddr   = tbl_addr(s_reg.op inside {MEX_OP_TBL_FINAL, MEX_OP_TBL_FINAL_PI},
                                              s_reg.thi, s_reg.tlo);
                    s_next.st      = MEX_ST_DUMMY;
                end
            end
            MEX_ST_DUMMY: begin
                // Program word comes back one cycle after its read strobe
                s_next.st = MEX_ST_EXEC;
            end
            MEX_ST_EXEC: begin
                s_next.st   = MEX_ST_IDLE;
                s_next.done = 1'b1;
                case (s_reg.op)
                    MEX_OP_TBL_PAGED, MEX_OP_TBL_FINAL, MEX_OP_TBL_PAGED_PI, MEX_OP_TBL_FINAL_PI: begin
                        // Program word returned: low byte to memory, high byte to latch
                        s_next.wdata   = pmem_rdata_i[MEX_DW-1:0];
                        s_next.tlatch  = pmem_rdata_i[MEX_PW-1:MEX_DW];
                        s_next.dmem_wr = 1'b1;
                    end
                    MEX_OP_SKZ: begin
                        s_next.wdata   = m;
                        s_next.dmem_wr = 1'b1;
                        s_next.skip_pend = is_zero(m);
                        s_next.skip      = is_zero(m);
                    end
                    MEX_OP_SKZ_LOAD: begin
                        s_next.acc       = m;
                        s_next.skip_pend = is_zero(m);
                        s_next.skip      = is_zero(m);
                    end
                    MEX_OP_SKZ_BIT: begin
                        s_next.skip_pend = ~m[s_reg.bsel];
                        s_next.skip      = ~m[s_reg.bsel];
                    end
                    MEX_OP_XOR_A, MEX_OP_XOR_M, MEX_OP_XOR_IMM,
                    MEX_OP_AND, MEX_OP_OR, MEX_OP_CPL, MEX_OP_DEC, MEX_OP_INC: begin
                        case (s_reg.op)
                            MEX_OP_XOR_IMM: res = s_reg.acc ^ s_reg.imm;
                            MEX_OP_XOR_A,
                            MEX_OP_XOR_M:   res = s_reg.acc ^ m;
                            MEX_OP_AND:     res = s_reg.acc & m;
                            MEX_OP_OR:      res = s_reg.acc | m;
                            MEX_OP_CPL:     res = ~m;
                            MEX_OP_DEC:     res = m - MEX_ONE;
                            default:        res = m + MEX_ONE;
                        endcase
                        s_next.flags[MEX_F_Z] = is_zero(res);
                        if (s_reg.op == MEX_OP_XOR_M ||
                            (s_reg.to_mem && s_reg.op != MEX_OP_XOR_A && s_reg.op != MEX_OP_XOR_IMM)) begin
                            s_next.wdata   = res;
                            s_next.dmem_wr = 1'b1;
                        end else begin
                            s_next.acc = res;
                        end
                    end
                    MEX_OP_ADD, MEX_OP_ADC: begin
                        cin  = (s_reg.op == MEX_OP_ADC) & s_reg.flags[MEX_F_C];
                        sum  = {1'b0, s_reg.acc} + {1'b0, m} + {{MEX_DW{1'b0}}, cin};
                        lsum = {1'b0, s_reg.acc[MEX_NIB-1:0]} + {1'b0, m[MEX_NIB-1:0]}
                               + {{MEX_NIB{1'b0}}, cin};
                        res  = sum[MEX_DW-1:0];
                        s_next.flags[MEX_F_C]  = sum[MEX_DW];
                        s_next.flags[MEX_F_AC] = lsum[MEX_NIB];
                        s_next.flags[MEX_F_Z]  = is_zero(res);
                        s_next.flags[MEX_F_OV] = (s_reg.acc[MEX_DW-1] == m[MEX_DW-1]) &&
                                                 (res[MEX_DW-1] != m[MEX_DW-1]);
                        s_next.flags[MEX_F_SC] = res[MEX_DW-1] ^ s_next.flags[MEX_F_OV];
                        if (s_reg.to_mem) begin
                            s_next.wdata   = res;
                            s_next.dmem_wr = 1'b1;
                        end else begin
                            s_next.acc = res;
                        end
                    end
                    MEX_OP_CLR: begin
                        s_next.wdata   = MEX_ZERO;
                        s_next.dmem_wr = 1'b1;
                    end
                    MEX_OP_CLR_BIT: begin
                        res = m;
                        res[s_reg.bsel] = 1'b0;
                        s_next.wdata   = res;
                        s_next.dmem_wr = 1'b1;
                    end
                    MEX_OP_BCD: begin
                        lo_fix = (s_reg.acc[MEX_NIB-1:0] > MEX_BCD_LIMIT) || s_reg.flags[MEX_F_AC];
                        hi_fix = (s_reg.acc[MEX_DW-1:MEX_NIB] > MEX_BCD_LIMIT) || s_reg.flags[MEX_F_C];
                        bcd = {1'b0, s_reg.acc} + {5'h00, (lo_fix ? MEX_BCD_FIX : 4'h0)}
                            + {1'b0, (hi_fix ? MEX_BCD_FIX : 4'h0), 4'h0};
                        s_next.wdata   = bcd[MEX_DW-1:0];
                        s_next.dmem_wr = 1'b1;
                        // Carry only ever set here, needed for multi-byte BCD
                        s_next.flags[MEX_F_C] = s_reg.flags[MEX_F_C] | bcd[MEX_DW] | hi_fix;
                    end
                    MEX_OP_MOV_TO_A: s_next.acc = m;
                    MEX_OP_MOV_TO_M: begin
                        s_next.wdata   = s_reg.acc;
                        s_next.dmem_wr = 1'b1;
                    end
                    default: ;
                endcase
            end
            default: s_next.st = MEX_ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers; reset brings only constants
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            if (!rstn_sync) begin
                s_reg        <= '0;
                s_reg.rst_q1 <= s_next.rst_q1;
                s_reg.rst_q2 <= s_next.rst_q2;
            end else begin
                s_reg <= s_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign busy_o               = s_reg.st != MEX_ST_IDLE;
    assign done_o               = s_reg.done;
    assign skip_o               = s_reg.skip;
    assign dmem_rd_o            = s_reg.dmem_rd;
    assign dmem_wr_o            = s_reg.dmem_wr;
    assign dmem_addr_o          = s_reg.addr;
    assign dmem_wdata_o         = s_reg.wdata;
    assign pmem_rd_o            = s_reg.pmem_rd;
    assign pmem_addr_o          = s_reg.paddr;
    assign working_register_o   = s_reg.acc;
    assign table_pointer_low_o  = s_reg.tlo;
    assign table_pointer_high_o = s_reg.thi;
    assign table_high_latch_o   = s_reg.tlatch;
    assign carry_o              = s_reg.flags[MEX_F_C];
    assign nibble_half_flag_o   = s_reg.flags[MEX_F_AC];
    assign zero_o               = s_reg.flags[MEX_F_Z];
    assign signed_range_flag_o  = s_reg.flags[MEX_F_OV];
    assign aux_signed_flag_o    = s_reg.flags[MEX_F_SC];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence seq_exec_skz;
        s_reg.st == MEX_ST_EXEC && s_reg.op == MEX_OP_SKZ;
    endsequence

    chk_skip_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        seq_exec_skz |=> (skip_o == (dmem_wdata_o == MEX_ZERO)) && dmem_wr_o)
        else $error("skip does not match zero byte");
    chk_load_acc: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        (s_reg.st == MEX_ST_EXEC && s_reg.op == MEX_OP_SKZ_LOAD) |=>
        skip_o == (working_register_o == MEX_ZERO))
        else $error("load skip mismatch");
    chk_skip_dummy: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        (skip_o && !busy_o ##1 start_i && !busy_o) |=> done_o && !busy_o && !dmem_wr_o)
        else $error("skipped slot not dummy");
    chk_bit_flags: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        (s_reg.st == MEX_ST_EXEC && s_reg.op == MEX_OP_SKZ_BIT) |=> $stable(s_reg.flags))
        else $error("bit test changed flags");
    chk_final_page: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        (pmem_rd_o && (s_reg.op == MEX_OP_TBL_FINAL || s_reg.op == MEX_OP_TBL_FINAL_PI)) |->
        pmem_addr_o == {{(PROG_W-MEX_DW){1'b1}}, table_pointer_low_o})
        else $error("final page address wrong");
    chk_preinc_ptr: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        (start_i && !busy_o && !s_reg.skip_pend && op_i == MEX_OP_TBL_PAGED_PI && !tbl_low_wr_i) |=>
        table_pointer_low_o == $past(table_pointer_low_o) + MEX_ONE)
        else $error("pointer not incremented");
    chk_table_split: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        (s_reg.st == MEX_ST_EXEC && is_table(s_reg.op)) |=> dmem_wr_o &&
        dmem_wdata_o == $past(pmem_rdata_i[MEX_DW-1:0]) &&
        table_high_latch_o == $past(pmem_rdata_i[MEX_PW-1:MEX_DW]))
        else $error("table word split wrong");
    chk_move_flags: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        (s_reg.st == MEX_ST_EXEC && (s_reg.op == MEX_OP_MOV_TO_A || s_reg.op == MEX_OP_MOV_TO_M
         || s_reg.op == MEX_OP_CLR)) |=> $stable(s_reg.flags))
        else $error("move changed flags");
    chk_suppress: assert property (@(posedge clk_sys_i) disable iff (!rstn_sync || !ce_i)
        (start_i && !busy_o && s_reg.skip_pend && !tbl_low_wr_i && !tbl_high_wr_i) |=>
        $stable(working_register_o) && $stable(s_reg.flags) && !dmem_wr_o && !busy_o)
        else $error("suppressed instruction had effect");

endmodule // mex_exec

//--- verilog/mex_pkg.sv
package mex_pkg;

    // ----------------------------------------------------------------
    // Operation codes issued by the core sequencer
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        MEX_OP_NOP,
        MEX_OP_SKZ,          // skip_if_mem_zero, memory form
        MEX_OP_SKZ_LOAD,     // skip_if_mem_zero_load
        MEX_OP_SKZ_BIT,      // bit test, skip when bit is 0
        MEX_OP_TBL_PAGED,    // table_fetch_paged
        MEX_OP_TBL_FINAL,    // table_fetch_final_page
        MEX_OP_TBL_PAGED_PI, // table_fetch_paged_preinc
        MEX_OP_TBL_FINAL_PI, // table_fetch_final_preinc
        MEX_OP_XOR_A,        // result to working register
        MEX_OP_XOR_M,        // exor_to_memory
        MEX_OP_XOR_IMM,
        MEX_OP_ADD,          // far_add
        MEX_OP_ADC,          // far_add_with_carry
        MEX_OP_AND,          // far_bitwise_conj
        MEX_OP_OR,           // far_bitwise_disj
        MEX_OP_CLR,          // far_clear_mem, whole byte
        MEX_OP_CLR_BIT,
        MEX_OP_CPL,          // far_invert_mem
        MEX_OP_BCD,          // far_bcd_adjust
        MEX_OP_DEC,          // far_decrement
        MEX_OP_INC,          // far_increment
        MEX_OP_MOV_TO_A,     // far_move, memory to working register
        MEX_OP_MOV_TO_M      // far_move, working register to memory
    } mex_op_t;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MEX_ST_IDLE,
        MEX_ST_READ,
        MEX_ST_EXEC,
        MEX_ST_DUMMY
    } mex_state_t;

    // ----------------------------------------------------------------
    // Widths and constants
    // ----------------------------------------------------------------
    localparam int          MEX_DW          = 8;
    localparam int          MEX_PW          = 16;
    localparam logic [7:0]  MEX_ZERO        = 8'h00;
    localparam logic [7:0]  MEX_ONE         = 8'h01;
    localparam logic [7:0]  MEX_ACC_RST     = 8'h00;
    localparam logic [3:0]  MEX_BCD_LIMIT   = 4'h9;
    localparam logic [3:0]  MEX_BCD_FIX     = 4'h6;
    localparam int          MEX_NIB         = 4;
    localparam int          MEX_FLAG_W      = 5;
    // Flag vector bit positions
    localparam int          MEX_F_C         = 0;
    localparam int          MEX_F_AC        = 1;
    localparam int          MEX_F_Z         = 2;
    localparam int          MEX_F_OV        = 3;
    localparam int          MEX_F_SC        = 4;

endpackage

//--- dv/mex_mem_model.sv
`timescale 1ns/100ps
// Behavioural data and program memories on the far side of the datapath
module mex_mem_model #(
    parameter int ADDR_W = 12,
    parameter int PROG_W = 13
) (
    // Clock
    input  wire logic              clk_sys_i,
    // Data memory side
    input  wire logic              rd_i,
    input  wire logic              wr_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    output logic      [7:0]        rdata_o = 8'h00,
    // Program memory side
    input  wire logic              prd_i,
    input  wire logic [PROG_W-1:0] paddr_i,
    output logic      [15:0]       prdata_o = 16'h0000
);
    logic [7:0] dmem [0:(1<<ADDR_W)-1];
    // One-cycle latency; each idle cycle inverts the last output, so a stale byte shows again after every second idle cycle
    always @(posedge clk_sys_i) begin
        if (wr_i) begin
            dmem[addr_i] <= wdata_i;
        end
        rdata_o  <= rd_i ? dmem[addr_i] : ~rdata_o;
        prdata_o <= prd_i ? (16'(paddr_i) ^ 16'hbc5a) : ~prdata_o;
    end
endmodule // mex_mem_model

//--- dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import mex_pkg::*;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, to_mem_i = 1'b0, tbl_low_wr_i = 1'b0, tbl_high_wr_i = 1'b0;
    logic [7:0] tbl_wdata_i = 8'h00, imm_i = 8'hff, dmem_rdata_i, dmem_wdata_o, working_register_o;
    logic [7:0] table_pointer_low_o, table_pointer_high_o, table_high_latch_o;
    logic busy_o, done_o, skip_o, dmem_rd_o, dmem_wr_o, pmem_rd_o, carry_o, nibble_half_flag_o, zero_o;
    logic signed_range_flag_o, aux_signed_flag_o;
    logic [11:0] mem_addr_i = 12'h000, dmem_addr_o;
    logic [12:0] pmem_addr_o;
    logic [15:0] pmem_rdata_i;
    logic [2:0] bit_sel_i = 3'h3;
    mex_op_t op_i = MEX_OP_NOP;
    int error_cnt = 0, comparisons = 0;
    logic skip_seen = 1'b0;
    // Clock enable tied high: freezing is not part of these scenarios
    mex_exec dut (.clk_sys_i, .rstn_i, .ce_i(1'b1), .start_i, .op_i, .mem_addr_i, .bit_sel_i, .imm_i, .to_mem_i,
        .busy_o, .done_o, .skip_o, .dmem_rd_o, .dmem_wr_o, .dmem_addr_o, .dmem_wdata_o, .dmem_rdata_i, .pmem_rd_o,
        .pmem_addr_o, .pmem_rdata_i, .tbl_low_wr_i, .tbl_high_wr_i, .tbl_wdata_i, .working_register_o,
        .table_pointer_low_o, .table_pointer_high_o, .table_high_latch_o, .carry_o, .nibble_half_flag_o, .zero_o,
        .signed_range_flag_o, .aux_signed_flag_o);
    mex_mem_model mem (.clk_sys_i, .rd_i(dmem_rd_o), .wr_i(dmem_wr_o), .addr_i(dmem_addr_o), .wdata_i(dmem_wdata_o),
        .rdata_o(dmem_rdata_i), .prd_i(pmem_rd_o), .paddr_i(pmem_addr_o), .prdata_o(pmem_rdata_i));
    always #20 clk_sys_i = ~clk_sys_i;
    // Compare and report
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Issue one request and wait for its completion pulse, bounded
    task automatic run(input mex_op_t o, input logic [11:0] a, input logic tm);
        int n;
        @(negedge clk_sys_i);
        op_i = o;
        mem_addr_i = a;
        to_mem_i = tm;
        start_i = 1'b1;
        @(negedge clk_sys_i);
        start_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        // Skip flag is a one-cycle pulse beside done, so keep it for the checks
        skip_seen = skip_o;
        check("done", n < 20, 1'b1);
        // Memory takes the write strobe at the next edge; read results after it
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic sc_incdec;
        mem.dmem[12'h123] = 8'hff;
        mem.dmem[12'hfff] = 8'h01;
        run(MEX_OP_INC, 12'h123, 1'b0);
        check("inc_acc", {zero_o, working_register_o}, 9'h100);
        check("inc_mem", mem.dmem[12'h123], 8'hff);
        run(MEX_OP_DEC, 12'hfff, 1'b1);
        check("dec_mem", {zero_o, mem.dmem[12'hfff]}, 9'h100);
    endtask
    task automatic sc_arith;
        mem.dmem[12'h010] = 8'h7f;
        mem.dmem[12'h011] = 8'h01;
        mem.dmem[12'h012] = 8'h80;
        mem.dmem[12'h013] = 8'h01;
        mem.dmem[12'h014] = 8'h3c;
        mem.dmem[12'h016] = 8'ha0;
        run(MEX_OP_MOV_TO_A, 12'h010, 1'b0);
        run(MEX_OP_ADD, 12'h011, 1'b0);
        check("add", {signed_range_flag_o, zero_o, nibble_half_flag_o, carry_o, aux_signed_flag_o,
            working_register_o}, 13'h1480);
        run(MEX_OP_ADC, 12'h012, 1'b1);
        check("adc_m", {carry_o, zero_o, mem.dmem[12'h012]}, 10'h300);
        run(MEX_OP_ADC, 12'h013, 1'b0);
        check("adc_a", {carry_o, working_register_o}, 9'h082);
        run(MEX_OP_MOV_TO_A, 12'h014, 1'b0);
        run(MEX_OP_BCD, 12'h015, 1'b0);
        check("bcd_lo", {carry_o, mem.dmem[12'h015]}, 9'h042);
        run(MEX_OP_MOV_TO_A, 12'h016, 1'b0);
        check("mov_a", working_register_o, 8'ha0);
        run(MEX_OP_BCD, 12'h017, 1'b0);
        check("bcd_hi", {zero_o, carry_o, mem.dmem[12'h017]}, 10'h100);
    endtask
    task automatic sc_logic;
        mem.dmem[12'h030] = 8'h0f;
        mem.dmem[12'h031] = 8'h5a;
        run(MEX_OP_AND, 12'h030, 1'b0);
        check("and", {zero_o, working_register_o}, 9'h100);
        run(MEX_OP_OR, 12'h031, 1'b1);
        check("or", {zero_o, mem.dmem[12'h031]}, 9'h05a);
        run(MEX_OP_XOR_IMM, 12'h031, 1'b0);
        run(MEX_OP_XOR_A, 12'h031, 1'b0);
        check("xor_a", working_register_o, 8'ha5);
        run(MEX_OP_XOR_M, 12'h031, 1'b1);
        check("xor_m", {zero_o, mem.dmem[12'h031]}, 9'h0ff);
        run(MEX_OP_CPL, 12'h031, 1'b1);
        check("cpl_m", {zero_o, mem.dmem[12'h031]}, 9'h100);
        run(MEX_OP_CPL, 12'h030, 1'b0);
        check("cpl_a", {zero_o, working_register_o, mem.dmem[12'h030]}, 17'h0f00f);
        run(MEX_OP_CLR_BIT, 12'h030, 1'b0);
        check("clr_bit", mem.dmem[12'h030], 8'h07);
        run(MEX_OP_CLR, 12'h030, 1'b0);
        check("clr", {zero_o, mem.dmem[12'h030]}, 9'h000);
        run(MEX_OP_MOV_TO_M, 12'h032, 1'b0);
        check("mov_m", mem.dmem[12'h032], 8'hf0);
    endtask
    task automatic sc_skip;
        mem.dmem[12'h040] = 8'h00;
        mem.dmem[12'h041] = 8'h07;
        mem.dmem[12'h043] = 8'hf7;
        run(MEX_OP_SKZ, 12'h040, 1'b0);
        check("skz", {skip_seen, mem.dmem[12'h040]}, 9'h100);
        run(MEX_OP_INC, 12'h040, 1'b1);
        check("swallow", mem.dmem[12'h040], 8'h00);
        run(MEX_OP_SKZ_LOAD, 12'h041, 1'b0);
        check("skzl_nz", {skip_seen, working_register_o}, 9'h007);
        run(MEX_OP_SKZ_LOAD, 12'h040, 1'b0);
        check("skzl_z", {skip_seen, working_register_o}, 9'h100);
        run(MEX_OP_MOV_TO_A, 12'h041, 1'b0);
        check("swallow_a", working_register_o, 8'h00);
        run(MEX_OP_SKZ_BIT, 12'h043, 1'b0);
        check("skz_bit", {skip_seen, carry_o}, 2'h3);
        run(MEX_OP_NOP, 12'h000, 1'b0);
    endtask
    task automatic sc_table;
        logic [7:0] lo;
        logic [15:0] w;
        lo = 8'h10;
        @(negedge clk_sys_i);
        tbl_low_wr_i = 1'b1;
        tbl_wdata_i = lo;
        @(negedge clk_sys_i);
        tbl_low_wr_i = 1'b0;
        tbl_high_wr_i = 1'b1;
        tbl_wdata_i = 8'h05;
        @(negedge clk_sys_i);
        tbl_high_wr_i = 1'b0;
        // Paged, final page, then both preincrement forms
        for (int i = 0; i < 4; i++) begin
            lo = (i >= 2) ? lo + 8'h01 : lo;
            w = 16'({(i % 2) ? 5'h1f : 5'h05, lo}) ^ 16'hbc5a;
            run(mex_op_t'(int'(MEX_OP_TBL_PAGED) + i), 12'h050 + 12'(i), 1'b0);
            check("tbl", {table_pointer_low_o, table_high_latch_o, mem.dmem[12'h050 + 12'(i)]}, {lo, w});
        end
        check("tbl_hi", table_pointer_high_o, 8'h05);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        sc_incdec();
        sc_arith();
        sc_logic();
        sc_skip();
        sc_table();
        print_verdict();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #(40 * 4000);
        error_cnt++;
        print_verdict();
    end
endmodule // testbench
